// ===== pxb_crossbar.sv
// Priority pin crossbar with its configuration registers and pin control.
//
// Function
// - Functions are placed in fixed priority order, serial port 0 first.
// - Each enabled movable resource takes the lowest free, unskipped pin.
// - A pin already given away is passed over for later resources.
// - Pins with their skip bit set count as already assigned.
// - Serial port 0 transmit sits on P0.4, receive on P0.5.
// - CAN transmit sits on P0.6, receive on P0.7.
// - Management bus data and clock pins are allocated together.
// - Serial, CAN and LIN transmit and receive pins are allocated together.
// - Unclaimed pins stay general-purpose port pins after the routed ones.
// - SPI takes three pins, four when slave-select mode routes select.
// - With the crossbar disabled all pins are plain input port pins.
// - Output drivers stay off while the crossbar is disabled.
// - Input mode bit 1 is digital, 0 analog; reset gives digital.
// - Analog pins lose pull-up, output driver and input receiver.
// - Each pin's output mode bit picks open-drain or push-pull.
// - Management bus pins are always open-drain.
// - With pull-up disable at 0, open-drain pins get weak pull-ups.
// - A pin driving low has its pull-up switched off.
// - Route enable 0 is an 8-bit read-write register resetting to zero.
// - Route enable 0 sits at address 0xE1 on page 0x0F.
// - Route enable 2 at 0xC7 holds pull-up disable and crossbar enable.
`timescale 1ns/1ps
`default_nettype none
module pxb_crossbar (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire pxb_pkg::pxb_sfr_req_type sfr_req,
  output logic      [7:0]               sfr_rdata_q,
  input  wire logic [1:0]               slave_select_mode_field,
  input  wire logic [pxb_pkg::NPIN-1:0] gpio_out_data,
  input  wire pxb_pkg::pxb_periph_type  periph_drv,
  output logic [pxb_pkg::NFUNC-1:0]     periph_in_q,
  input  wire logic [pxb_pkg::NPIN-1:0] pad_in,
  output logic [pxb_pkg::NPIN-1:0]      pad_out_q,
  output logic [pxb_pkg::NPIN-1:0]      pad_oe_q,
  output logic [pxb_pkg::NPIN-1:0]      pad_pullup_q,
  output logic [pxb_pkg::NPIN-1:0]      pad_rx_en_q
);
  import pxb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.
  logic [7:0]      crossbar_route_enable_0_q;
  logic [7:0]      crossbar_route_enable_2_q;
  logic [NPIN-1:0] pin_skip_mask_q;
  logic [NPIN-1:0] pin_input_mode_q;
  logic [NPIN-1:0] pin_output_mode_q;

  wire page_hit_w = sfr_req.wr && (sfr_req.page == SFR_PAGE_XBAR);
  wire wr_re0_w   = page_hit_w && (sfr_req.addr == ADDR_ROUTE_EN0);
  wire wr_re2_w   = page_hit_w && (sfr_req.addr == ADDR_ROUTE_EN2);
  wire wr_skip0_w = page_hit_w && (sfr_req.addr == ADDR_SKIP0);
  wire wr_skip1_w = page_hit_w && (sfr_req.addr == ADDR_SKIP1);
  wire wr_in0_w   = page_hit_w && (sfr_req.addr == ADDR_IN_MODE0);
  wire wr_in1_w   = page_hit_w && (sfr_req.addr == ADDR_IN_MODE1);
  wire wr_out0_w  = page_hit_w && (sfr_req.addr == ADDR_OUT_MODE0);
  wire wr_out1_w  = page_hit_w && (sfr_req.addr == ADDR_OUT_MODE1);

  always_ff @(posedge clk) begin
    if (rst) begin
      crossbar_route_enable_0_q <= RST_ROUTE;
      crossbar_route_enable_2_q <= RST_ROUTE;
    end else begin
      if (wr_re0_w) crossbar_route_enable_0_q <= sfr_req.wdata;
      if (wr_re2_w) crossbar_route_enable_2_q <= sfr_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_skip_mask_q   <= {RST_SKIP, RST_SKIP};
      pin_input_mode_q  <= {RST_IN_MODE, RST_IN_MODE};
      pin_output_mode_q <= {RST_OUT_MODE, RST_OUT_MODE};
    end else begin
      if (wr_skip0_w) pin_skip_mask_q[7:0]    <= sfr_req.wdata;
      if (wr_skip1_w) pin_skip_mask_q[15:8]   <= sfr_req.wdata;
      if (wr_in0_w)   pin_input_mode_q[7:0]   <= sfr_req.wdata;
      if (wr_in1_w)   pin_input_mode_q[15:8]  <= sfr_req.wdata;
      if (wr_out0_w)  pin_output_mode_q[7:0]  <= sfr_req.wdata;
      if (wr_out1_w)  pin_output_mode_q[15:8] <= sfr_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path; the pin readback registers show the live pad levels of digital pins, analog pins read 0.
  logic [7:0] rd_mux_w;

  always_comb begin
    rd_mux_w = 8'h00;
    if (sfr_req.page == SFR_PAGE_XBAR) begin
      case (sfr_req.addr)
        ADDR_ROUTE_EN0: rd_mux_w = crossbar_route_enable_0_q;
        ADDR_ROUTE_EN2: rd_mux_w = crossbar_route_enable_2_q;
        ADDR_SKIP0:     rd_mux_w = pin_skip_mask_q[7:0];
        ADDR_SKIP1:     rd_mux_w = pin_skip_mask_q[15:8];
        ADDR_IN_MODE0:  rd_mux_w = pin_input_mode_q[7:0];
        ADDR_IN_MODE1:  rd_mux_w = pin_input_mode_q[15:8];
        ADDR_OUT_MODE0: rd_mux_w = pin_output_mode_q[7:0];
        ADDR_OUT_MODE1: rd_mux_w = pin_output_mode_q[15:8];
        ADDR_PIN_READ0: rd_mux_w = pad_in[7:0] & pin_input_mode_q[7:0];
        ADDR_PIN_READ1: rd_mux_w = pad_in[15:8] & pin_input_mode_q[15:8];
        default:        rd_mux_w = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) sfr_rdata_q <= 8'h00;
    else     sfr_rdata_q <= rd_mux_w;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Route requests; nothing is requested while the crossbar is off.
  wire crossbar_enable_bit   = crossbar_route_enable_2_q[RE2_XBAR_ON];
  wire global_pullup_disable = crossbar_route_enable_2_q[RE2_PU_OFF];
  wire serial0_route_en      = crossbar_enable_bit & crossbar_route_enable_0_q[RE0_URT0];
  wire can_route_en          = crossbar_enable_bit & crossbar_route_enable_0_q[RE0_CAN];
  wire serial_periph_route_en = crossbar_enable_bit & crossbar_route_enable_0_q[RE0_SPI];
  wire mgmt_bus_route_en     = crossbar_enable_bit & crossbar_route_enable_0_q[RE0_SMB];
  wire serial1_route_en      = crossbar_enable_bit & crossbar_route_enable_2_q[RE2_URT1];
  wire lin_route_en          = crossbar_enable_bit & crossbar_route_enable_2_q[RE2_LIN];
  wire nss_needed_w          = slave_select_mode_field != 2'b00;

  logic [NSLOT-1:0] slot_req_w;

  assign slot_req_w[F_SCK-NFIX]   = serial_periph_route_en;
  assign slot_req_w[F_MISO-NFIX]  = serial_periph_route_en;
  assign slot_req_w[F_MOSI-NFIX]  = serial_periph_route_en;
  assign slot_req_w[F_NSS-NFIX]   = serial_periph_route_en & nss_needed_w;
  assign slot_req_w[F_SDA-NFIX]   = mgmt_bus_route_en;
  assign slot_req_w[F_SCL-NFIX]   = mgmt_bus_route_en;
  assign slot_req_w[F_CP0-NFIX]   = crossbar_enable_bit & crossbar_route_enable_0_q[RE0_CP0];
  assign slot_req_w[F_CP0A-NFIX]  = crossbar_enable_bit & crossbar_route_enable_0_q[RE0_CP0A];
  assign slot_req_w[F_CP1-NFIX]   = crossbar_enable_bit & crossbar_route_enable_0_q[RE0_CP1];
  assign slot_req_w[F_CP1A-NFIX]  = crossbar_enable_bit & crossbar_route_enable_0_q[RE0_CP1A];
  assign slot_req_w[F_U1TX-NFIX]  = serial1_route_en;
  assign slot_req_w[F_U1RX-NFIX]  = serial1_route_en;
  assign slot_req_w[F_LINTX-NFIX] = lin_route_en;
  assign slot_req_w[F_LINRX-NFIX] = lin_route_en;

  ////////////////////////////////////////////////////////////////////////////////
  // Placement: fixed pairs first, then the priority chain around them.
  logic [NFUNC-1:0][NPIN-1:0] route_sel_w;
  logic [NPIN-1:0]            fixed_mask_w;

  assign route_sel_w[F_U0TX]  = serial0_route_en ? NPIN'(1) << PIN_U0TX : '0;
  assign route_sel_w[F_U0RX]  = serial0_route_en ? NPIN'(1) << PIN_U0RX : '0;
  assign route_sel_w[F_CANTX] = can_route_en ? NPIN'(1) << PIN_CANTX : '0;
  assign route_sel_w[F_CANRX] = can_route_en ? NPIN'(1) << PIN_CANRX : '0;
  assign fixed_mask_w = route_sel_w[F_U0TX] | route_sel_w[F_U0RX]
                      | route_sel_w[F_CANTX] | route_sel_w[F_CANRX];

  // A pair that does not fit whole is still placed pin by pin, as far as pins last.
  pxb_alloc u_alloc (
    .req     (slot_req_w),
    .blocked (pin_skip_mask_q | fixed_mask_w),
    .sel     (route_sel_w[NFUNC-1:NFIX])
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Per-pin drive selection and mode handling.
  logic [NPIN-1:0] oe_w;
  logic [NPIN-1:0] out_w;
  logic [NPIN-1:0] pullup_w;
  logic [NPIN-1:0] rx_en_w;
  logic [NPIN-1:0] claimed_w;
  logic [NPIN-1:0] smb_pin_w;

  localparam logic [NFUNC-1:0] SMB_FUNCS = (NFUNC'(1) << F_SDA) | (NFUNC'(1) << F_SCL);

  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    logic [NFUNC-1:0] owner_w;
    for (genvar f = 0; f < NFUNC; f++) begin : g_col
      assign owner_w[f] = route_sel_w[f][p];
    end
    wire own_drv_w = |(owner_w & periph_drv.oe);
    wire own_val_w = |(owner_w & periph_drv.oe & periph_drv.val);
    // Unclaimed pins and idle peripheral lines fall back to the port latch.
    wire drive_w   = own_drv_w ? own_val_w : gpio_out_data[p];
    assign claimed_w[p] = |owner_w;
    assign smb_pin_w[p] = |(owner_w & SMB_FUNCS);

    pxb_pin_cell u_cell (
      .xbar_on   (crossbar_enable_bit),
      .digital   (pin_input_mode_q[p]),
      .push_pull (pin_output_mode_q[p]),
      .force_od  (smb_pin_w[p]),
      .pu_off    (global_pullup_disable),
      .drive_val (drive_w),
      .oe        (oe_w[p]),
      .out       (out_w[p]),
      .pu_en     (pullup_w[p]),
      .rx_en     (rx_en_w[p])
    );
  end

  // Unrouted peripheral inputs idle high so a receiver sees a quiet line.
  logic [NFUNC-1:0] func_in_w;
  for (genvar f = 0; f < NFUNC; f++) begin : g_func
    assign func_in_w[f] = (|route_sel_w[f]) ? |(route_sel_w[f] & pad_in & rx_en_w) : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pad_out_q    <= RST_PINS;
      pad_oe_q     <= RST_PINS;
      pad_pullup_q <= RST_PINS;
      pad_rx_en_q  <= RST_PINS;
      periph_in_q  <= RST_FUNC_IN;
    end else begin
      pad_out_q    <= out_w;
      pad_oe_q     <= oe_w;
      pad_pullup_q <= pullup_w;
      pad_rx_en_q  <= rx_en_w;
      periph_in_q  <= func_in_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  drivers_off_a: assert property (
    !crossbar_enable_bit |=> pad_oe_q == '0)
    else $error("pad driver enabled while crossbar disabled");

  inputs_idle_a: assert property (
    !crossbar_enable_bit |-> claimed_w == '0 ##1 periph_in_q == RST_FUNC_IN)
    else $error("routing active while crossbar disabled");

  uart_fixed_a: assert property (
    serial0_route_en |-> route_sel_w[F_U0TX][PIN_U0TX] && route_sel_w[F_U0RX][PIN_U0RX])
    else $error("serial port 0 not on its fixed pins");

  can_fixed_a: assert property (
    can_route_en |-> route_sel_w[F_CANTX][PIN_CANTX] && route_sel_w[F_CANRX][PIN_CANRX])
    else $error("CAN not on its fixed pins");

  skip_honoured_a: assert property (
    ((claimed_w & ~fixed_mask_w) & pin_skip_mask_q) == '0)
    else $error("skipped pin given to a movable resource");

  analog_quiet_a: assert property (
    1'b1 |=> ((pad_oe_q | pad_pullup_q | pad_rx_en_q) & ~$past(pin_input_mode_q)) == '0)
    else $error("analog pin has driver, pull-up or receiver on");

  smb_open_drain_a: assert property (
    1'b1 |=> (pad_oe_q & pad_out_q & $past(smb_pin_w)) == '0)
    else $error("management bus pin driven high");

  low_no_pullup_a: assert property (
    (pad_pullup_q & pad_oe_q & ~pad_out_q) == '0)
    else $error("pull-up on while driving low");

  od_pullup_a: assert property (
    !global_pullup_disable |=> (($past(pin_input_mode_q & ~(pin_output_mode_q & ~smb_pin_w))
      & ~pad_pullup_q & ~(pad_oe_q & ~pad_out_q)) == '0))
    else $error("open-drain pin lacks weak pull-up");

  input_reset_a: assert property (
    $past(rst) |-> pin_input_mode_q == {RST_IN_MODE, RST_IN_MODE})
    else $error("input mode not digital after reset");

  smb_pair_a: assert property (
    slot_req_w[F_SDA-NFIX] == slot_req_w[F_SCL-NFIX])
    else $error("management bus pins requested apart");

  uart1_pair_a: assert property (
    slot_req_w[F_U1TX-NFIX] == slot_req_w[F_U1RX-NFIX])
    else $error("serial port 1 pins requested apart");

  lin_pair_a: assert property (
    slot_req_w[F_LINTX-NFIX] == slot_req_w[F_LINRX-NFIX])
    else $error("LIN pins requested apart");

  spi_set_a: assert property (
    slot_req_w[F_SCK-NFIX] == slot_req_w[F_MISO-NFIX]
      && slot_req_w[F_SCK-NFIX] == slot_req_w[F_MOSI-NFIX])
    else $error("SPI data pins requested apart");

  nss_gate_a: assert property (
    slot_req_w[F_NSS-NFIX] |-> slot_req_w[F_SCK-NFIX] && nss_needed_w)
    else $error("slave select requested without four-wire mode");

  nss_mode_a: assert property (
    !nss_needed_w |-> route_sel_w[F_NSS] == '0)
    else $error("slave select routed in three-wire mode");

  off_no_route_a: assert property (
    !crossbar_enable_bit |-> route_sel_w == '0)
    else $error("function routed while crossbar disabled");

  lowest_pin_a: assert property (
    slot_req_w[F_SCK-NFIX]
      |-> ((route_sel_w[F_SCK] - NPIN'(1)) & ~(pin_skip_mask_q | fixed_mask_w)) == '0)
    else $error("first slot not on the lowest free pin");

  single_pin_a: assert property (
    $onehot0(route_sel_w[F_SCK]))
    else $error("one slot placed on several pins");

  pp_drives_a: assert property (
    crossbar_enable_bit
      |=> ($past(pin_input_mode_q & pin_output_mode_q & ~smb_pin_w) & ~pad_oe_q) == '0)
    else $error("push-pull pin not driven");

  od_no_high_a: assert property (
    1'b1 |=> (pad_oe_q & pad_out_q & ~$past(pin_output_mode_q)) == '0)
    else $error("open-drain pin driven high");

  pp_no_pullup_a: assert property (
    1'b1 |=> (pad_pullup_q & $past(pin_output_mode_q & ~smb_pin_w)) == '0)
    else $error("push-pull pin has weak pull-up");

  rx_mode_a: assert property (
    1'b1 |=> pad_rx_en_q == $past(pin_input_mode_q))
    else $error("receiver enable differs from input mode");

  pud_off_a: assert property (
    global_pullup_disable |=> pad_pullup_q == '0)
    else $error("weak pull-up on while globally disabled");

  route0_write_a: assert property (
    wr_re0_w |=> crossbar_route_enable_0_q == $past(sfr_req.wdata))
    else $error("route enable 0 write lost");

  route2_write_a: assert property (
    wr_re2_w |=> crossbar_route_enable_2_q == $past(sfr_req.wdata))
    else $error("route enable 2 write lost");

  other_page_a: assert property (
    sfr_req.wr && sfr_req.page != SFR_PAGE_XBAR |=> $stable(crossbar_route_enable_0_q))
    else $error("write on another page changed route enable 0");

  gpio_unclaimed_a: assert property (
    crossbar_enable_bit |=> ((pad_out_q ^ $past(gpio_out_data))
      & $past(~claimed_w & pin_output_mode_q)) == '0)
    else $error("unclaimed push-pull pin ignores port latch");

  analog_read_a: assert property (
    sfr_req.page == SFR_PAGE_XBAR && sfr_req.addr == ADDR_PIN_READ1
      |=> (sfr_rdata_q & ~$past(pin_input_mode_q[15:8])) == '0)
    else $error("analog pin visible in readback");

endmodule
`default_nettype wire

// ===== pxb_pkg.sv
// Package with the constants and carrier types of the priority pin crossbar.
package pxb_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes.
  localparam int NPIN  = 16;
  localparam int NSLOT = 14;
  localparam int NFIX  = 4;
  localparam int NFUNC = NFIX + NSLOT;

  ////////////////////////////////////////////////////////////////////////////////
  // Function indices; fixed functions first, then crossbar slots in priority order.
  localparam int F_U0TX  = 0;
  localparam int F_U0RX  = 1;
  localparam int F_CANTX = 2;
  localparam int F_CANRX = 3;
  localparam int F_SCK   = 4;
  localparam int F_MISO  = 5;
  localparam int F_MOSI  = 6;
  localparam int F_NSS   = 7;
  localparam int F_SDA   = 8;
  localparam int F_SCL   = 9;
  localparam int F_CP0   = 10;
  localparam int F_CP0A  = 11;
  localparam int F_CP1   = 12;
  localparam int F_CP1A  = 13;
  localparam int F_U1TX  = 14;
  localparam int F_U1RX  = 15;
  localparam int F_LINTX = 16;
  localparam int F_LINRX = 17;

  // Fixed pin positions of port 0.
  localparam int PIN_U0TX  = 4;
  localparam int PIN_U0RX  = 5;
  localparam int PIN_CANTX = 6;
  localparam int PIN_CANRX = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Special function register map.
  localparam logic [7:0] SFR_PAGE_XBAR   = 8'h0F;
  localparam logic [7:0] ADDR_ROUTE_EN0  = 8'hE1;
  localparam logic [7:0] ADDR_ROUTE_EN2  = 8'hC7;
  localparam logic [7:0] ADDR_SKIP0      = 8'hD4;
  localparam logic [7:0] ADDR_SKIP1      = 8'hD5;
  localparam logic [7:0] ADDR_IN_MODE0   = 8'hF1;
  localparam logic [7:0] ADDR_IN_MODE1   = 8'hF2;
  localparam logic [7:0] ADDR_OUT_MODE0  = 8'hA4;
  localparam logic [7:0] ADDR_OUT_MODE1  = 8'hA5;
  localparam logic [7:0] ADDR_PIN_READ0  = 8'hD8;
  localparam logic [7:0] ADDR_PIN_READ1  = 8'hD9;

  // Field positions of route enable 0.
  localparam int RE0_URT0 = 0;
  localparam int RE0_CAN  = 1;
  localparam int RE0_SPI  = 2;
  localparam int RE0_SMB  = 3;
  localparam int RE0_CP0  = 4;
  localparam int RE0_CP0A = 5;
  localparam int RE0_CP1  = 6;
  localparam int RE0_CP1A = 7;

  // Field positions of route enable 2.
  localparam int RE2_LIN     = 0;
  localparam int RE2_URT1    = 1;
  localparam int RE2_XBAR_ON = 6;
  localparam int RE2_PU_OFF  = 7;

  // Reset values.
  localparam logic [7:0]      RST_ROUTE    = 8'h00;
  localparam logic [7:0]      RST_SKIP     = 8'h00;
  localparam logic [7:0]      RST_OUT_MODE = 8'h00;
  localparam logic [7:0]      RST_IN_MODE  = 8'hFF;
  localparam logic [NPIN-1:0] RST_PINS     = 16'h0000;
  localparam logic [NFUNC-1:0] RST_FUNC_IN = 18'h3_FFFF;

  ////////////////////////////////////////////////////////////////////////////////
  // Carrier types.
  typedef struct packed {
    logic [NFUNC-1:0] val;
    logic [NFUNC-1:0] oe;
  } pxb_periph_type;

  typedef struct packed {
    logic       wr;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pxb_sfr_req_type;

endpackage

// ===== pxb_alloc.sv
// Priority chain that places each requested slot on the lowest free pin.
`timescale 1ns/1ps
`default_nettype none
module pxb_alloc (
  input  wire logic [pxb_pkg::NSLOT-1:0]                    req,
  input  wire logic [pxb_pkg::NPIN-1:0]                     blocked,
  output logic      [pxb_pkg::NSLOT-1:0][pxb_pkg::NPIN-1:0] sel
);
  import pxb_pkg::*;

  logic [NSLOT:0][NPIN-1:0] taken;

  // Skipped and fixed pins start out as taken.
  assign taken[0] = blocked;

  // Slot order is the priority order; each stage sees what earlier ones took.
  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    wire [NPIN-1:0] free_w   = ~taken[s];
    wire [NPIN-1:0] lowest_w = free_w & (NPIN'(~free_w) + NPIN'(1));
    assign sel[s]     = req[s] ? lowest_w : '0;
    assign taken[s+1] = taken[s] | sel[s];
  end

endmodule
`default_nettype wire

// ===== pxb_pin_cell.sv
// Mode handling of one pin: driver enable, output level, pull-up and receiver.
`timescale 1ns/1ps
`default_nettype none
module pxb_pin_cell (
  input  wire logic xbar_on,
  input  wire logic digital,
  input  wire logic push_pull,
  input  wire logic force_od,
  input  wire logic pu_off,
  input  wire logic drive_val,
  output logic      oe,
  output logic      out,
  output logic      pu_en,
  output logic      rx_en
);

  wire pp_w     = push_pull & ~force_od;
  wire active_w = xbar_on & digital;

  // Open drain only pulls low; a high level leaves the pad to the pull-up.
  assign oe     = active_w & (pp_w | ~drive_val);
  assign out    = pp_w & drive_val;
  assign pu_en  = digital & ~pu_off & ~pp_w & ~(oe & ~out);
  assign rx_en  = digital;

endmodule
`default_nettype wire

// ===== pxb_pad_model.sv
// Board-side model of the port pads and of anything that drives them from outside.
`timescale 1ns/1ps
`default_nettype none
module pxb_pad_model (
  input  wire logic                     clk,
  input  wire logic [pxb_pkg::NPIN-1:0] pad_out,
  input  wire logic [pxb_pkg::NPIN-1:0] pad_oe,
  input  wire logic [pxb_pkg::NPIN-1:0] pad_pullup,
  input  wire logic [pxb_pkg::NPIN-1:0] ext_oe,
  input  wire logic [pxb_pkg::NPIN-1:0] ext_val,
  output logic      [pxb_pkg::NPIN-1:0] pad_in
);
  import pxb_pkg::*;
  // A pad nobody drives or pulls toggles every cycle, so a stale level never passes.
  logic [NPIN-1:0] float_q = 16'h0000;
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_oe[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_pullup[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = float_q[i];
      end
    end
  end
endmodule
`default_nettype wire

// ===== pxb_crossbar_tb.sv
// Self-checking testbench of the priority pin crossbar.
`timescale 1ns/1ps
`default_nettype none
module pxb_crossbar_tb;
  import pxb_pkg::*;
  logic            clk;
  logic            rst;
  pxb_sfr_req_type sfr_req;
  logic [7:0]      sfr_rdata_q;
  logic [1:0]      ssm;
  logic [NPIN-1:0] gpio_out_data;
  pxb_periph_type  periph_drv;
  logic [NFUNC-1:0] periph_in_q;
  logic [NPIN-1:0] pad_in;
  logic [NPIN-1:0] pad_out_q;
  logic [NPIN-1:0] pad_oe_q;
  logic [NPIN-1:0] pad_pullup_q;
  logic [NPIN-1:0] pad_rx_en_q;
  logic [NPIN-1:0] ext_oe;
  logic [NPIN-1:0] ext_val;
  int              n_errors = 0;
  int              n_tests = 0;

  pxb_crossbar dut_u (
    .clk                     (clk),
    .rst                     (rst),
    .sfr_req                 (sfr_req),
    .sfr_rdata_q             (sfr_rdata_q),
    .slave_select_mode_field (ssm),
    .gpio_out_data           (gpio_out_data),
    .periph_drv              (periph_drv),
    .periph_in_q             (periph_in_q),
    .pad_in                  (pad_in),
    .pad_out_q               (pad_out_q),
    .pad_oe_q                (pad_oe_q),
    .pad_pullup_q            (pad_pullup_q),
    .pad_rx_en_q             (pad_rx_en_q)
  );

  pxb_pad_model pad_u (
    .clk        (clk),
    .pad_out    (pad_out_q),
    .pad_oe     (pad_oe_q),
    .pad_pullup (pad_pullup_q),
    .ext_oe     (ext_oe),
    .ext_val    (ext_val),
    .pad_in     (pad_in)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #5;
    sfr_req = '{wr: 1'b1, page: page, addr: addr, wdata: data};
    @(posedge clk);
    #5;
    sfr_req.wr = 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    #5;
    sfr_req = '{wr: 1'b0, page: SFR_PAGE_XBAR, addr: addr, wdata: 8'h00};
    @(posedge clk);
    #5;
    chk(what, 18'(exp), 18'(sfr_rdata_q));
  endtask

  // Pad register and peripheral input register each take a cycle, routing none, so four is ample.
  task automatic settle();
    repeat (4) @(posedge clk);
    #5;
  endtask

  task automatic pins_chk(input logic [15:0] oe, input logic [15:0] out, input logic [15:0] pu);
    settle();
    chk("pad_oe", 18'(oe), 18'(pad_oe_q));
    chk("pad_out", 18'(out), 18'(pad_out_q));
    chk("pad_pullup", 18'(pu), 18'(pad_pullup_q));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    sfr_req = '0;
    ssm = 2'b00;
    gpio_out_data = '0;
    periph_drv = '0;
    ext_oe = '0;
    ext_val = '0;
    repeat (20) @(posedge clk);
    #5;
    rst = 1'b0;
    pins_chk(16'h0000, 16'h0000, 16'hFFFF);
    chk("rx_en", 18'(16'hFFFF), 18'(pad_rx_en_q));
    rd_chk("route0 reset", ADDR_ROUTE_EN0, 8'h00);
    rd_chk("route2 reset", ADDR_ROUTE_EN2, 8'h00);
    rd_chk("in_mode reset", ADDR_IN_MODE0, 8'hFF);
    wr(SFR_PAGE_XBAR, ADDR_ROUTE_EN0, 8'hA5);
    rd_chk("route0 rw", ADDR_ROUTE_EN0, 8'hA5);
    wr(8'h00, ADDR_ROUTE_EN0, 8'h5A);
    rd_chk("route0 page", ADDR_ROUTE_EN0, 8'hA5);
    rd_chk("unmapped", 8'h80, 8'h00);
    $display("test registers done");
    // Push-pull everywhere, P0.0 and P0.2 skipped, four functions routed, crossbar off.
    wr(SFR_PAGE_XBAR, ADDR_OUT_MODE0, 8'hFF);
    wr(SFR_PAGE_XBAR, ADDR_OUT_MODE1, 8'hFF);
    wr(SFR_PAGE_XBAR, ADDR_SKIP0, 8'h05);
    wr(SFR_PAGE_XBAR, ADDR_ROUTE_EN0, 8'h0F);
    gpio_out_data = 16'hFFFF;
    ext_oe = 16'hFFFF;
    ext_val = 16'hA55A;
    pins_chk(16'h0000, 16'hFFFF, 16'h0000);
    rd_chk("pin read0", ADDR_PIN_READ0, 8'h5A);
    rd_chk("pin read1", ADDR_PIN_READ1, 8'hA5);
    $display("test disabled done");
    ext_oe = 16'h0000;
    periph_drv.oe = '1;
    periph_drv.val = '0;
    periph_drv.val[F_SDA] = 1'b1;
    periph_drv.val[F_SCL] = 1'b1;
    wr(SFR_PAGE_XBAR, ADDR_ROUTE_EN2, 8'h40);
    pins_chk(16'hF9FF, 16'hF805, 16'h0600);
    chk("miso in", 18'(1'b0), 18'(periph_in_q[F_MISO]));
    chk("cp0 in", 18'(1'b1), 18'(periph_in_q[F_CP0]));
    $display("test three wire done");
    ssm = 2'b01;
    pins_chk(16'hF3FF, 16'hF005, 16'h0C00);
    wr(SFR_PAGE_XBAR, ADDR_SKIP1, 8'h01);
    pins_chk(16'hE7FF, 16'hE105, 16'h1800);
    $display("test four wire done");
    wr(SFR_PAGE_XBAR, ADDR_IN_MODE1, 8'h00);
    settle();
    chk("analog oe", 18'(16'h00FF), 18'(pad_oe_q & 16'hFF00 | 16'h00FF));
    chk("analog pu", 18'(16'h0000), 18'(pad_pullup_q & 16'hFF00));
    chk("analog rx", 18'(16'h00FF), 18'(pad_rx_en_q));
    rd_chk("analog read", ADDR_PIN_READ1, 8'h00);
    $display("test analog done");
    wr(SFR_PAGE_XBAR, ADDR_IN_MODE1, 8'hFF);
    wr(SFR_PAGE_XBAR, ADDR_SKIP1, 8'h00);
    wr(SFR_PAGE_XBAR, ADDR_ROUTE_EN0, 8'h00);
    wr(SFR_PAGE_XBAR, ADDR_OUT_MODE0, 8'h00);
    wr(SFR_PAGE_XBAR, ADDR_OUT_MODE1, 8'h00);
    gpio_out_data = 16'h00FF;
    ssm = 2'b00;
    pins_chk(16'hFF00, 16'h0000, 16'h00FF);
    rd_chk("od read0", ADDR_PIN_READ0, 8'hFF);
    rd_chk("od read1", ADDR_PIN_READ1, 8'h00);
    wr(SFR_PAGE_XBAR, ADDR_ROUTE_EN2, 8'hC0);
    pins_chk(16'hFF00, 16'h0000, 16'h0000);
    $display("test open drain done");
    wr(SFR_PAGE_XBAR, ADDR_ROUTE_EN2, 8'h00);
    settle();
    chk("off oe", 18'(16'h0000), 18'(pad_oe_q));
    chk("off periph in", 18'h3_FFFF, 18'(periph_in_q));
    $display("test disable again done");
    close_out();
  end
endmodule
`default_nettype wire
